// ---- inc/hmap_pkg.sv ----
/*
 package of the host memory access port: widths, pin positions on the
 shared host pins, the strap settle count, the state encoding and the fifo shape.
 assumes it is compiled before every design file that uses it.
*/
`default_nettype none
package hmap_pkg;

	// bus and word widths
	localparam int BUS_W = 16;
	localparam int WIDE_BUS_W = 32;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int WIDE_W = 24;
	localparam int PINS_W = 12;

	// bit positions inside a latched address word
	localparam int TYPE_BIT = 15;
	localparam int ADDR_LSB = 0;

	// shared pin positions (index = pin number minus one)
	localparam int PIN_RD = 4;
	localparam int PIN_WR = 5;
	localparam int PIN_SEL = 6;
	localparam int PIN_AL = 7;
	localparam int PIN_ACK = 8;
	localparam int PIN_FL0 = 9;
	localparam int FLAG_W = 3;

	// first data memory word holding control registers; plain default
	localparam logic [13:0] CTRL_REG_BASE = 14'h3fe0;

	// cycles after reset release before the synchronised straps are taken
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// fifo between the write side of the port and the memory
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = 1 + ADDR_W + WIDE_W;

	// reset values
	localparam logic [13:0] ADDR_RESET = 14'h0000;
	localparam logic ACK_IDLE_N = 1'b1;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RD_DRAIN = 5'b00010,
		ST_RD_ISSUE = 5'b00100,
		ST_RD_LOAD = 5'b01000,
		ST_RD_HOLD = 5'b10000
	} port_state_e;

endpackage
`default_nettype wire

// ---- verilog/pin_sync.sv ----
/*
 two flip-flop synchroniser for a group of pins.
 assumes each bit is a level that is stable for more than two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] pins_out
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_s;

	sync_s r;
	sync_s r_nxt;

	// first stage feeds only the second stage
	always_comb begin
		r_nxt = r;
		r_nxt.first = pins_in;
		r_nxt.second = r.first;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign pins_out = r.second;

endmodule
`default_nettype wire

// ---- verilog/word_fifo.sv ----
/*
 synchronous fifo with valid/ready on both sides.
 assumes one clock; depth is a power of two or not, pointers wrap explicitly.
*/
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] count;
	} fifo_s;

	fifo_s r;
	fifo_s r_nxt;
	logic push;
	logic pop;

	// full and empty come from the count, so both sides see honest flags
	always_comb begin
		r_nxt = r;
		in_ready = (r.count != FULL);
		out_valid = (r.count != '0);
		out_data = r.mem[r.rptr];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			r_nxt.mem[r.wptr] = in_data;
			r_nxt.wptr = (r.wptr == LAST) ? '0 : r.wptr + 1'b1;
		end
		if (pop) begin
			r_nxt.rptr = (r.rptr == LAST) ? '0 : r.rptr + 1'b1;
		end
		if (push && !pop) begin
			r_nxt.count = r.count + 1'b1;
		end else if (pop && !push) begin
			r_nxt.count = r.count - 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

endmodule
`default_nettype wire

// ---- verilog/host_memory_access_port.sv ----
/*
 host memory access port: the shared host pins run either as an
 asynchronous multiplexed address/data port into on-chip program and data
 memory, or are handed to a pci core; straps taken after reset pick the
 personality and the boot source.
 assumes the memory answers a request one cycle later, that mem_ready
 grants the memory for the following cycle, and that the pci core and the
 processor sit on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

//Contract
// R1 - host reads and writes program, data memory
// R2 - host writes never reach control registers
// R3 - 16-bit muxed bus, 16/24-bit words
// R4 - host strobes accepted asynchronously
// R5 - address auto-increments after each transfer
// R6 - host drives address and type after ack
// R7 - address latched on latch falling edge
// R8 - host requests with select plus read/write
// R9 - one sync cycle, then one access cycle; code synchronises strobes through two flip-flops before the access
// R10 - processor can load the address register
// R11 - personality straps pick port or pci
// R12 - personality fixed after reset
// R13 - boot straps pick byte, host, external
// R14 - boot straps ignored after reset
// R15 - host boot works in either personality
// R16 - pci personality carries pci pin set
// R17 - acknowledge shows port ready
// R18 - bit 15 type, bits 13:0 address
module host_memory_access_port (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [11:0] shared_host_pins_in,
	output logic [11:0] shared_host_pins_out,
	output logic [11:0] shared_host_pins_oe,
	input wire logic [31:0] shared_bus_in,
	output logic [31:0] shared_bus_out,
	output logic [1:0] shared_bus_oe,
	output logic flag7_irq_pin,
	input wire logic bus_personality_strap,
	input wire logic bus_select_strap,
	input wire logic boot_source_strap_a,
	input wire logic boot_source_strap_b,
	output logic straps_valid,
	output logic pci_mode,
	output logic idma_mode,
	output logic boot_from_byte_mem,
	output logic boot_from_host,
	output logic boot_from_ext_mem,
	output logic [11:0] pci_pins_in,
	input wire logic [11:0] pci_pin_out,
	input wire logic [11:0] pci_pin_oe,
	output logic [31:0] pci_bus_in,
	input wire logic [31:0] pci_ad_out,
	input wire logic pci_ad_oe,
	input wire logic pci_inta_req,
	input wire logic [2:0] flag_out,
	input wire logic gp_flag7,
	input wire logic core_addr_load,
	input wire logic [15:0] core_addr_value,
	output logic [15:0] host_port_address_reg,
	input wire logic mem_ready,
	output logic mem_req,
	output logic mem_write,
	output logic mem_is_data,
	output logic [13:0] mem_addr,
	output logic [23:0] mem_wdata,
	input wire logic [23:0] mem_rdata
);

	typedef struct packed {
		hmap_pkg::port_state_e st;
		logic rd_n_p;
		logic wr_n_p;
		logic sel_n_p;
		logic al_p;
		logic [15:0] bus_p;
		logic [13:0] addr;
		logic is_data;
		logic wide_low;
		logic [15:0] wide_hi;
		logic [23:0] rd_word;
		logic [1:0] strap_wait;
		logic straps_done;
		logic pci_mode;
		logic idma_mode;
		logic boot_byte;
		logic boot_host;
		logic boot_ext;
		logic [11:0] pin_out;
		logic [11:0] pin_oe;
		logic [31:0] bus_out;
		logic [1:0] bus_oe;
		logic flag7;
		logic mem_req;
		logic mem_we;
		logic mem_data_sel;
		logic [13:0] mem_addr;
		logic [23:0] mem_wdata;
	} port_state_s;

	port_state_s r;
	port_state_s r_nxt;

	logic [11:0] pins_s;
	logic [31:0] bus_s;
	logic [3:0] straps_s;
	logic s_rd_n;
	logic s_wr_n;
	logic s_sel_n;
	logic s_al;
	logic wr_done;
	logic rd_start;
	logic rd_end;
	logic al_fall;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [hmap_pkg::FIFO_W-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [hmap_pkg::FIFO_W-1:0] fifo_out_data;
	logic drain_data;
	logic [13:0] drain_addr;
	logic [23:0] drain_word;
	logic drain_blocked;

	// every pin and strap crosses two flip-flops before any logic sees it
	pin_sync #(
		.WIDTH(48)
	) u_pin_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.pins_in({boot_source_strap_b, boot_source_strap_a, bus_select_strap,
			bus_personality_strap, shared_bus_in, shared_host_pins_in}),
		.pins_out({straps_s, bus_s, pins_s})
	); // R4

	// host writes queue here so a busy memory does not lose words
	word_fifo #(
		.WIDTH(hmap_pkg::FIFO_W),
		.DEPTH(hmap_pkg::FIFO_DEPTH)
	) u_word_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// port strobes as seen after synchronisation
	assign s_rd_n = pins_s[hmap_pkg::PIN_RD];
	assign s_wr_n = pins_s[hmap_pkg::PIN_WR];
	assign s_sel_n = pins_s[hmap_pkg::PIN_SEL];
	assign s_al = pins_s[hmap_pkg::PIN_AL];

	// strobe events, all but rd_end only live in port personality
	assign al_fall = r.idma_mode && r.al_p && !s_al; // R7
	assign wr_done = r.idma_mode && !r.wr_n_p && !r.sel_n_p && (s_wr_n || s_sel_n); // R8
	assign rd_start = r.idma_mode && !s_rd_n && !s_sel_n && (r.rd_n_p || r.sel_n_p); // R8
	assign rd_end = s_rd_n || s_sel_n;

	// fifo word is {type, address, 24-bit data}
	assign drain_data = fifo_out_data[hmap_pkg::FIFO_W-1];
	assign drain_addr = fifo_out_data[hmap_pkg::WIDE_W +: hmap_pkg::ADDR_W];
	assign drain_word = fifo_out_data[hmap_pkg::WIDE_W-1:0];
	assign drain_blocked = drain_data && (drain_addr >= hmap_pkg::CTRL_REG_BASE); // R2

	// whole port: straps, pin mux, address, read sequence and write drain
	always_comb begin
		r_nxt = r;
		fifo_in_valid = 1'b0;
		fifo_in_data = '0;
		fifo_out_ready = 1'b0;
		r_nxt.rd_n_p = s_rd_n;
		r_nxt.wr_n_p = s_wr_n;
		r_nxt.sel_n_p = s_sel_n;
		r_nxt.al_p = s_al;
		r_nxt.bus_p = bus_s[15:0];
		r_nxt.mem_req = 1'b0;
		r_nxt.mem_we = 1'b0;

		// straps are taken once, after the synchroniser has filled
		if (!r.straps_done) begin
			if (r.strap_wait == hmap_pkg::STRAP_SETTLE) begin
				r_nxt.straps_done = 1'b1;
				r_nxt.pci_mode = straps_s[0] && !straps_s[1]; // R11
				r_nxt.idma_mode = !straps_s[0] && !straps_s[1]; // R11
				r_nxt.boot_byte = !straps_s[2] && !straps_s[3]; // R13
				r_nxt.boot_host = straps_s[2] && !straps_s[3]; // R13 R15
				r_nxt.boot_ext = !straps_s[2] && straps_s[3]; // R13
			end else begin
				r_nxt.strap_wait = r.strap_wait + 2'h1;
			end
		end // R12 R14

		// drain queued writes whenever memory is granted
		fifo_out_ready = mem_ready;
		if (fifo_out_valid && mem_ready) begin
			r_nxt.mem_req = !drain_blocked; // R2
			r_nxt.mem_we = 1'b1;
			r_nxt.mem_data_sel = drain_data;
			r_nxt.mem_addr = drain_addr;
			r_nxt.mem_wdata = drain_word; // R1
		end

		// address register: processor load wins over a host latch
		if (core_addr_load) begin
			r_nxt.addr = core_addr_value[hmap_pkg::ADDR_LSB +: hmap_pkg::ADDR_W]; // R10
			r_nxt.is_data = core_addr_value[hmap_pkg::TYPE_BIT]; // R18
			r_nxt.wide_low = 1'b0;
		end else if (al_fall && r.st == hmap_pkg::ST_IDLE) begin
			r_nxt.addr = r.bus_p[hmap_pkg::ADDR_LSB +: hmap_pkg::ADDR_W]; // R7 R6
			r_nxt.is_data = r.bus_p[hmap_pkg::TYPE_BIT]; // R18
			r_nxt.wide_low = 1'b0;
		end

		// transfer sequence; program words move as upper 16 then lower 8 bits
		case (r.st)
			hmap_pkg::ST_IDLE: begin
				if (wr_done && !core_addr_load) begin
					if (r.is_data) begin
						fifo_in_valid = 1'b1;
						fifo_in_data = {1'b1, r.addr, 8'h00, r.bus_p}; // R3
						if (fifo_in_ready) begin
							r_nxt.addr = r.addr + 14'h0001; // R5
						end
					end else if (!r.wide_low) begin
						r_nxt.wide_hi = r.bus_p;
						r_nxt.wide_low = 1'b1;
					end else begin
						fifo_in_valid = 1'b1;
						fifo_in_data = {1'b0, r.addr, r.wide_hi, r.bus_p[7:0]}; // R3
						if (fifo_in_ready) begin
							r_nxt.wide_low = 1'b0;
							r_nxt.addr = r.addr + 14'h0001; // R5
						end
					end
				end else if (rd_start && !core_addr_load) begin
					if (!r.is_data && r.wide_low) begin
						// lower byte already held, no memory cycle needed
						r_nxt.bus_out[15:0] = {r.rd_word[7:0], 8'h00};
						r_nxt.bus_oe[0] = 1'b1;
						r_nxt.st = hmap_pkg::ST_RD_HOLD;
					end else begin
						r_nxt.st = hmap_pkg::ST_RD_DRAIN;
					end
				end
			end
			hmap_pkg::ST_RD_DRAIN: begin
				// reads wait behind queued writes to keep host order
				if (rd_end) begin
					r_nxt.st = hmap_pkg::ST_IDLE;
				end else if (!fifo_out_valid && mem_ready) begin
					r_nxt.mem_req = 1'b1; // R9
					r_nxt.mem_we = 1'b0;
					r_nxt.mem_data_sel = r.is_data;
					r_nxt.mem_addr = r.addr;
					r_nxt.st = hmap_pkg::ST_RD_ISSUE;
				end
			end
			hmap_pkg::ST_RD_ISSUE: begin
				r_nxt.st = hmap_pkg::ST_RD_LOAD;
			end
			hmap_pkg::ST_RD_LOAD: begin
				r_nxt.rd_word = mem_rdata; // R1
				r_nxt.bus_out[15:0] = r.is_data ? mem_rdata[15:0] : mem_rdata[23:8]; // R3
				r_nxt.bus_oe[0] = 1'b1;
				r_nxt.st = hmap_pkg::ST_RD_HOLD;
			end
			hmap_pkg::ST_RD_HOLD: begin
				if (rd_end) begin
					r_nxt.bus_oe[0] = 1'b0;
					r_nxt.st = hmap_pkg::ST_IDLE;
					if (r.is_data || r.wide_low) begin
						r_nxt.wide_low = 1'b0;
						r_nxt.addr = r.addr + 14'h0001; // R5
					end else begin
						r_nxt.wide_low = 1'b1;
					end
				end
			end
			default: begin
				r_nxt.st = hmap_pkg::ST_IDLE;
			end
		endcase

		// pin personality; nothing is driven until the straps are known
		if (!r.straps_done) begin
			r_nxt.pin_oe = '0;
			r_nxt.bus_oe = 2'h0;
			r_nxt.flag7 = 1'b0;
		end else if (r.pci_mode) begin
			r_nxt.pin_out = pci_pin_out; // R16
			r_nxt.pin_oe = pci_pin_oe; // R16
			r_nxt.bus_out = pci_ad_out; // R16
			r_nxt.bus_oe = {2{pci_ad_oe}};
			r_nxt.flag7 = pci_inta_req; // R16
		end else if (r.idma_mode) begin
			r_nxt.pin_out = '0;
			r_nxt.pin_oe = '0;
			// ready only when idle and a write would find room
			r_nxt.pin_out[hmap_pkg::PIN_ACK] = !(r_nxt.st == hmap_pkg::ST_IDLE
				&& fifo_in_ready && !fifo_in_valid); // R17
			r_nxt.pin_oe[hmap_pkg::PIN_ACK] = 1'b1;
			r_nxt.pin_out[hmap_pkg::PIN_FL0 +: hmap_pkg::FLAG_W] = flag_out;
			r_nxt.pin_oe[hmap_pkg::PIN_FL0 +: hmap_pkg::FLAG_W] = 3'h7;
			r_nxt.bus_out[31:16] = 16'h0000;
			r_nxt.bus_oe[1] = 1'b0;
			r_nxt.flag7 = gp_flag7;
		end else begin
			// reserved strap code: keep the shared pins quiet
			r_nxt.pin_oe = '0;
			r_nxt.bus_oe = 2'h0;
			r_nxt.flag7 = gp_flag7;
		end
	end

	// constants only under reset; acknowledge idles not-ready
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.st <= hmap_pkg::ST_IDLE;
			r.addr <= hmap_pkg::ADDR_RESET;
			r.pin_out[hmap_pkg::PIN_ACK] <= hmap_pkg::ACK_IDLE_N;
		end else begin
			r <= r_nxt;
		end
	end

	// outputs straight from flip-flops
	assign shared_host_pins_out = r.pin_out;
	assign shared_host_pins_oe = r.pin_oe;
	assign shared_bus_out = r.bus_out;
	assign shared_bus_oe = r.bus_oe;
	assign flag7_irq_pin = r.flag7;
	assign straps_valid = r.straps_done;
	assign pci_mode = r.pci_mode;
	assign idma_mode = r.idma_mode;
	assign boot_from_byte_mem = r.boot_byte;
	assign boot_from_host = r.boot_host;
	assign boot_from_ext_mem = r.boot_ext;
	assign pci_pins_in = pins_s;
	assign pci_bus_in = bus_s;
	assign host_port_address_reg = {r.is_data, 1'b0, r.addr};
	assign mem_req = r.mem_req;
	assign mem_write = r.mem_we;
	assign mem_is_data = r.mem_data_sel;
	assign mem_addr = r.mem_addr;
	assign mem_wdata = r.mem_wdata;

endmodule
`default_nettype wire

// ---- testbench/hmap_chk.sv ----
/*
 checker for the host memory access port, bound to its top module.
 assumes one clock domain and the port's own ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module hmap_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [11:0] shared_host_pins_out,
	input wire logic flag7_irq_pin,
	input wire logic gp_flag7,
	input wire logic straps_valid,
	input wire logic pci_mode,
	input wire logic idma_mode,
	input wire logic boot_from_byte_mem,
	input wire logic boot_from_host,
	input wire logic boot_from_ext_mem,
	input wire logic core_addr_load,
	input wire logic [15:0] core_addr_value,
	input wire logic [15:0] host_port_address_reg,
	input wire logic mem_ready,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic mem_is_data,
	input wire logic [13:0] mem_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// straps frozen once captured
	property p_mode_held;
		$past(straps_valid) |-> $stable(idma_mode) && $stable(pci_mode);
	endproperty
	a_mode_held: assert property (p_mode_held) else $error("bus mode changed");
	property p_boot_held;
		$past(straps_valid) |-> $stable({boot_from_byte_mem, boot_from_host, boot_from_ext_mem});
	endproperty
	a_boot_held: assert property (p_boot_held) else $error("boot source changed");
	property p_boot_one;
		$onehot0({boot_from_byte_mem, boot_from_host, boot_from_ext_mem}) && !(pci_mode && idma_mode);
	endproperty
	a_boot_one: assert property (p_boot_one) else $error("decode not exclusive");
	// control words must never be written by the host
	property p_ctrl_guard;
		mem_req && mem_write && mem_is_data |-> mem_addr < hmap_pkg::CTRL_REG_BASE;
	endproperty
	a_ctrl_guard: assert property (p_ctrl_guard) else $error("control word written");
	property p_core_load;
		core_addr_load |=> host_port_address_reg ==
			{$past(core_addr_value[15]), 1'b0, $past(core_addr_value[13:0])};
	endproperty
	a_core_load: assert property (p_core_load) else $error("address load lost");
	property p_grant;
		mem_req |-> $past(mem_ready);
	endproperty
	a_grant: assert property (p_grant) else $error("memory used without grant");
	property p_flag7;
		$past(idma_mode, 2) && idma_mode |-> flag7_irq_pin == $past(gp_flag7);
	endproperty
	a_flag7: assert property (p_flag7) else $error("flag pin wrong");
	property p_ack_busy;
		idma_mode && mem_req && !mem_write |-> shared_host_pins_out[8];
	endproperty
	a_ack_busy: assert property (p_ack_busy) else $error("ready shown while busy");
endmodule
bind host_memory_access_port hmap_chk chk_i (.core_clk, .reset_n, .shared_host_pins_out,
	.flag7_irq_pin, .gp_flag7, .straps_valid, .pci_mode, .idma_mode, .boot_from_byte_mem,
	.boot_from_host, .boot_from_ext_mem, .core_addr_load, .core_addr_value,
	.host_port_address_reg, .mem_ready, .mem_req, .mem_write, .mem_is_data, .mem_addr);
`default_nettype wire

// ---- testbench/host_cpu_model.sv ----
/*
 model of the external host on the port pins: latch, write, read.
 assumes the bench merges its bus with the port's driven lanes.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	input wire logic core_clk,
	input wire logic ack_n,
	input wire logic [15:0] bus_from_dut,
	input wire logic bus_oe,
	output logic [11:0] pins,
	output logic [15:0] bus
);
	logic [15:0] last = 16'h0000;
	logic drive = 1'b0;
	// waits that ran out, read back by the bench as a mismatch
	int misses = 0;
	initial pins = 12'h070;
	// released lines show the inverse, never a stale value
	assign bus = drive ? last : ~last;
	task hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// strobes are slow against the core clock, so wait for ready first
	task wait_ack;
		int i;
		i = 0;
		while (ack_n !== 1'b0 && i < 200) begin
			@(posedge core_clk);
			i++;
		end
		if (ack_n !== 1'b0)
			misses++;
	endtask
	task latch(input logic [15:0] a);
		wait_ack();
		last <= a;
		drive <= 1'b1;
		pins[7] <= 1'b1;
		hold(4);
		pins[7] <= 1'b0;
		hold(4);
		drive <= 1'b0;
		// one edge with the bus released before the next call drives it
		hold(1);
	endtask
	task write(input logic [15:0] v);
		wait_ack();
		last <= v;
		drive <= 1'b1;
		pins[6:5] <= 2'b00;
		hold(4);
		pins[6:5] <= 2'b11;
		hold(4);
		drive <= 1'b0;
		hold(1);
	endtask
	task read(output logic [15:0] v);
		int i;
		wait_ack();
		pins[6] <= 1'b0;
		pins[4] <= 1'b0;
		i = 0;
		@(posedge core_clk);
		while (bus_oe !== 1'b1 && i < 30) begin
			@(posedge core_clk);
			i++;
		end
		if (bus_oe !== 1'b1)
			misses++;
		v = bus_from_dut;
		pins[6] <= 1'b1;
		pins[4] <= 1'b1;
		hold(4);
	endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 bench for the host memory access port: host model, memory model, checks.
 assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk = 0, reset_n = 0;
	logic [11:0] shared_host_pins_in, shared_host_pins_out, shared_host_pins_oe;
	logic [15:0] host_bus, host_port_address_reg, d;
	logic [31:0] shared_bus_in, shared_bus_out;
	logic [1:0] shared_bus_oe;
	logic bus_personality_strap = 0, bus_select_strap = 0;
	logic boot_source_strap_a = 1, boot_source_strap_b = 0;
	logic straps_valid, pci_mode, idma_mode, flag7_irq_pin;
	logic boot_from_byte_mem, boot_from_host, boot_from_ext_mem;
	logic [2:0] flag_out = 3'h0;
	logic [11:0] pci_pin_out = 12'h000, pci_pin_oe = 12'h000, pci_pins_in;
	logic [31:0] pci_ad_out = 32'h00000000, pci_bus_in;
	logic pci_ad_oe = 0, pci_inta_req = 0;
	logic gp_flag7 = 0, core_addr_load = 0, mem_ready = 1;
	logic [15:0] core_addr_value = 16'h0000;
	logic mem_req, mem_write, mem_is_data;
	logic [13:0] mem_addr;
	logic [23:0] mem_wdata, mem_rdata = 24'h000000;
	logic [23:0] data_mem [0:16383];
	logic [23:0] prog_mem [0:16383];
	int num_errors = 0, cmp_count = 0, i, k;
	always #5 core_clk = ~core_clk;
	host_memory_access_port dut (.core_clk, .reset_n, .shared_host_pins_in,
		.shared_host_pins_out, .shared_host_pins_oe, .shared_bus_in, .shared_bus_out,
		.shared_bus_oe, .flag7_irq_pin, .bus_personality_strap, .bus_select_strap,
		.boot_source_strap_a, .boot_source_strap_b, .straps_valid, .pci_mode, .idma_mode,
		.boot_from_byte_mem, .boot_from_host, .boot_from_ext_mem, .pci_pins_in,
		.pci_pin_out, .pci_pin_oe, .pci_bus_in, .pci_ad_out, .pci_ad_oe, .pci_inta_req, .flag_out,
		.gp_flag7, .core_addr_load, .core_addr_value, .host_port_address_reg, .mem_ready,
		.mem_req, .mem_write, .mem_is_data, .mem_addr, .mem_wdata, .mem_rdata);
	host_cpu_model host (.core_clk, .ack_n(shared_host_pins_out[8]),
		.bus_from_dut(shared_bus_out[15:0]), .bus_oe(shared_bus_oe[0]),
		.pins(shared_host_pins_in), .bus(host_bus));
	assign shared_bus_in = {~host_bus, shared_bus_oe[0] ? shared_bus_out[15:0] : host_bus};
	// memory answers one cycle after a read, then scrambles its data
	initial data_mem[14'h3fe0] = 24'h000000;
	always @(posedge core_clk) begin
		mem_rdata <= ~mem_rdata;
		if (mem_req && mem_write && mem_is_data)
			data_mem[mem_addr] <= mem_wdata;
		if (mem_req && mem_write && !mem_is_data)
			prog_mem[mem_addr] <= mem_wdata;
		if (mem_req && !mem_write)
			mem_rdata <= mem_is_data ? data_mem[mem_addr] : prog_mem[mem_addr];
	end
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// whole run is a few hundred cycles, far inside the 20000-cycle limit
	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		chk("early_oe", 12'h000, shared_host_pins_oe);
		i = 0;
		while (straps_valid !== 1'b1 && i < 20) begin
			@(posedge core_clk);
			i++;
		end
		@(posedge core_clk);
		chk("idma_mode", 1, idma_mode);
		chk("pci_off", 0, pci_mode);
		chk("boot_host", 1, boot_from_host);
		chk("boot_byte", 0, boot_from_byte_mem);
		bus_personality_strap <= 1'b1;
		boot_source_strap_a <= 1'b0;
		boot_source_strap_b <= 1'b1;
		flag_out <= 3'h5;
		gp_flag7 <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("mode_held", 1, idma_mode);
		chk("boot_held", 1, boot_from_host);
		chk("flags", 3'h5, shared_host_pins_out[11:9]);
		chk("port_oe", 12'hf00, shared_host_pins_oe);
		chk("gp_flag7", 1, flag7_irq_pin);
		// stalled memory: fill the fifo until ready drops
		mem_ready <= 1'b0;
		host.latch(16'h8020);
		chk("addr_latch", 16'h8020, host_port_address_reg);
		for (k = 0; k < 8; k++)
			host.write(16'h1100 + k[15:0]);
		repeat (4) @(posedge core_clk);
		chk("ack_full", 1, shared_host_pins_out[8]);
		chk("addr_inc", 16'h8028, host_port_address_reg);
		mem_ready <= 1'b1;
		host.latch(16'h8020);
		for (k = 0; k < 8; k++) begin
			host.read(d);
			chk("data_read", 16'h1100 + k[15:0], d);
		end
		host.latch(16'hbfe0);
		host.write(16'h5555);
		repeat (10) @(posedge core_clk);
		chk("ctrl_guard", 0, data_mem[14'h3fe0][15:0]);
		// program word goes in two halves
		host.latch(16'h0005);
		host.write(16'habcd);
		host.write(16'h00ef);
		repeat (10) @(posedge core_clk);
		chk("wide_word", 24'habcdef, prog_mem[5]);
		host.latch(16'h0005);
		host.read(d);
		chk("wide_hi", 16'habcd, d);
		host.read(d);
		chk("wide_lo", 16'hef00, d);
		core_addr_value <= 16'h8021;
		core_addr_load <= 1'b1;
		@(posedge core_clk);
		core_addr_load <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("core_load", 16'h8021, host_port_address_reg);
		host.read(d);
		chk("core_read", 16'h1101, d);
		// second power-up reset: straps now ask for pci and external boot
		reset_n <= 1'b0;
		pci_pin_out <= 12'ha5c;
		pci_pin_oe <= 12'h3f6;
		pci_ad_out <= 32'h1234abcd;
		pci_ad_oe <= 1'b1;
		pci_inta_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("reset_valid", 0, straps_valid);
		reset_n <= 1'b1;
		i = 0;
		while (straps_valid !== 1'b1 && i < 20) begin
			@(posedge core_clk);
			i++;
		end
		repeat (4) @(posedge core_clk);
		chk("pci_mode", 1, pci_mode);
		chk("idma_off", 0, idma_mode);
		chk("boot_ext", 1, boot_from_ext_mem);
		chk("pci_pins", 12'ha5c, shared_host_pins_out);
		chk("pci_oe", 12'h3f6, shared_host_pins_oe);
		chk("pci_ad_hi", 16'h1234, shared_bus_out[31:16]);
		chk("pci_ad_lo", 16'habcd, shared_bus_out[15:0]);
		chk("pci_ad_oe", 2'h3, shared_bus_oe);
		chk("inta", 1, flag7_irq_pin);
		chk("pci_pins_in", 12'h070, pci_pins_in);
		chk("pci_bus_in", 16'habcd, pci_bus_in[15:0]);
		chk("host_timeouts", 0, 24'(host.misses));
		wrap_up();
	end
endmodule
`default_nettype wire
